// [adc_readout.sv]
// eight-channel readout: two converters, four inputs each, on-demand sampling,
// per-channel moving average of 1 to 9 points.
// assumes two external 12-bit converters with start/done/data ports; done and
// data arrive from outside the clock domain and are synchronised here.
`timescale 1ns/1ns
module adc_readout
#(
  parameter int SAMPLE_BITS = adc_readout_pkg::SAMPLE_BITS,
  parameter int MAX_DEPTH   = adc_readout_pkg::MAX_DEPTH
)
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // request side
  input  wire logic                   req_valid,
  input  wire logic [3:0]             req_chan,
  input  wire logic                   avg_enable,
  input  wire logic [3:0]             avg_depth,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output logic [3:0]                  rsp_chan,
  output logic [SAMPLE_BITS-1:0]      rsp_data,
  output logic                        rsp_error,
  // converter A, channels 1..4
  output logic                        conv_a_start,
  output logic [1:0]                  conv_a_mux,
  input  wire logic                   conv_a_done,
  input  wire logic [SAMPLE_BITS-1:0] conv_a_data,
  // converter B, channels 5..8
  output logic                        conv_b_start,
  output logic [1:0]                  conv_b_mux,
  input  wire logic                   conv_b_done,
  input  wire logic [SAMPLE_BITS-1:0] conv_b_data
);

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_WAIT, ST_STORE, ST_SUM, ST_DIV} state_e;

  // synchronisers for converter outputs
  logic                   a_done_s1;
  logic                   a_done_s2;
  logic                   b_done_s1;
  logic                   b_done_s2;
  logic [SAMPLE_BITS-1:0] a_data_s1;
  logic [SAMPLE_BITS-1:0] a_data_s2;
  logic [SAMPLE_BITS-1:0] b_data_s1;
  logic [SAMPLE_BITS-1:0] b_data_s2;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      a_done_s1 <= 1'b0;
      a_done_s2 <= 1'b0;
      b_done_s1 <= 1'b0;
      b_done_s2 <= 1'b0;
      a_data_s1 <= '0;
      a_data_s2 <= '0;
      b_data_s1 <= '0;
      b_data_s2 <= '0;
    end
    else
    begin
      a_done_s1 <= conv_a_done;
      a_done_s2 <= a_done_s1;
      b_done_s1 <= conv_b_done;
      b_done_s2 <= b_done_s1;
      a_data_s1 <= conv_a_data;
      a_data_s2 <= a_data_s1;
      b_data_s1 <= conv_b_data;
      b_data_s2 <= b_data_s1;
    end
  end

  // history memory, one ring per channel
  logic [SAMPLE_BITS-1:0] hist [adc_readout_pkg::CHAN_COUNT][MAX_DEPTH];
  logic [3:0]             wr_ptr [adc_readout_pkg::CHAN_COUNT];
  logic [3:0]             fill [adc_readout_pkg::CHAN_COUNT];

  // clamp requested depth to 1..MAX_DEPTH
  function automatic logic [3:0] eff_depth(input logic en, input logic [3:0] d);
    logic [3:0] r;
    r = d;
    if (!en || d == 4'h0)
      r = 4'h1;
    else if (d > 4'(MAX_DEPTH))
      r = 4'(MAX_DEPTH);
    return r;
  endfunction

  // request channel index into converter select: true for channels above four (second converter)
  function automatic logic on_second(input logic [3:0] ch);
    return ch > 4'(adc_readout_pkg::CHAN_PER_CONV);
  endfunction

  state_e                 state;
  state_e                 next_state;
  logic [2:0]             cur_idx;
  logic [2:0]             next_cur_idx;
  logic [3:0]             cur_chan;
  logic [3:0]             next_cur_chan;
  logic [3:0]             cur_depth;
  logic [3:0]             next_cur_depth;
  logic                   use_b;
  logic                   next_use_b;
  logic [SAMPLE_BITS-1:0] sample;
  logic [SAMPLE_BITS-1:0] next_sample;
  logic [SAMPLE_BITS+3:0] acc;
  logic [SAMPLE_BITS+3:0] next_acc;
  logic [3:0]             sum_i;
  logic [3:0]             next_sum_i;
  logic [3:0]             cnt;
  logic [3:0]             next_cnt;
  logic [SAMPLE_BITS-1:0] quot;
  logic [SAMPLE_BITS-1:0] next_quot;
  logic                   next_req_ready;
  logic                   next_rsp_valid;
  logic [3:0]             next_rsp_chan;
  logic [SAMPLE_BITS-1:0] next_rsp_data;
  logic                   next_rsp_error;
  logic                   next_a_start;
  logic                   next_b_start;
  logic [1:0]             next_a_mux;
  logic [1:0]             next_b_mux;
  logic                   do_store;
  logic                   done_seen;
  logic [3:0]             ring_idx;

  assign done_seen = use_b ? b_done_s2 : a_done_s2;

  always_comb
  begin
    next_state     = state;
    next_cur_idx   = cur_idx;
    next_cur_chan  = cur_chan;
    next_cur_depth = cur_depth;
    next_use_b     = use_b;
    next_sample    = sample;
    next_acc       = acc;
    next_sum_i     = sum_i;
    next_cnt       = cnt;
    next_quot      = quot;
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_chan  = rsp_chan;
    next_rsp_data  = rsp_data;
    next_rsp_error = rsp_error;
    next_a_start   = 1'b0;
    next_b_start   = 1'b0;
    next_a_mux     = conv_a_mux;
    next_b_mux     = conv_b_mux;
    do_store       = 1'b0;
    ring_idx       = 4'h0;
    case (state)
      ST_IDLE:
      begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready)
        begin
          next_req_ready = 1'b0;
          if (req_chan < adc_readout_pkg::CHAN_FIRST || req_chan > adc_readout_pkg::CHAN_LAST)
          begin
            // out of range index answers at once with an error, no sampling
            next_rsp_valid = 1'b1;
            next_rsp_chan  = req_chan;
            next_rsp_data  = '0;
            next_rsp_error = 1'b1;
            next_state     = ST_IDLE;
          end
          else
          begin
            next_cur_chan  = req_chan;
            next_cur_idx   = 3'(req_chan - 4'h1);
            next_cur_depth = eff_depth(avg_enable, avg_depth);
            next_use_b     = on_second(req_chan);
            next_state     = ST_START;
          end
        end
      end
      ST_START:
      begin
        // sampling starts only from a request; the idle state never converts
        if (use_b)
        begin
          next_b_start = 1'b1;
          next_b_mux   = 2'(cur_idx - 3'h4);
        end
        else
        begin
          next_a_start = 1'b1;
          next_a_mux   = cur_idx[1:0];
        end
        next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (done_seen)
        begin
          next_sample = use_b ? b_data_s2 : a_data_s2;
          next_state  = ST_STORE;
        end
      end
      ST_STORE:
      begin
        do_store   = 1'b1;
        next_cnt   = (fill[cur_idx] < cur_depth) ? fill[cur_idx] + 4'h1 : cur_depth;
        next_acc   = '0;
        next_sum_i = 4'h0;
        next_state = ST_SUM;
        if (cur_depth == 4'h1)
        begin
          // single point: pass the fresh sample through untouched
          next_rsp_valid = 1'b1;
          next_rsp_chan  = cur_chan;
          next_rsp_data  = sample;
          next_rsp_error = 1'b0;
          next_state     = ST_IDLE;
        end
      end
      ST_SUM:
      begin
        // walk back from the newest entry over the window
        ring_idx = (wr_ptr[cur_idx] >= sum_i + 4'h1) ? wr_ptr[cur_idx] - sum_i - 4'h1
                 : 4'(MAX_DEPTH) + wr_ptr[cur_idx] - sum_i - 4'h1;
        next_acc   = acc + (SAMPLE_BITS+4)'(hist[cur_idx][ring_idx]);
        next_sum_i = sum_i + 4'h1;
        next_quot  = '0;
        if (sum_i + 4'h1 == cnt)
          next_state = ST_DIV;
      end
      ST_DIV:
      begin
        // divide by repeated subtraction: one step per count of the mean
        if (acc >= (SAMPLE_BITS+4)'(cnt))
        begin
          next_acc  = acc - (SAMPLE_BITS+4)'(cnt);
          next_quot = quot + SAMPLE_BITS'(1);
        end
        else
        begin
          next_rsp_valid = 1'b1;
          next_rsp_chan  = cur_chan;
          next_rsp_data  = quot;
          next_rsp_error = 1'b0;
          next_state     = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state        <= ST_IDLE;
      cur_idx      <= 3'h0;
      cur_chan     <= 4'h0;
      cur_depth    <= adc_readout_pkg::DEPTH_RESET;
      use_b        <= 1'b0;
      sample       <= '0;
      acc          <= '0;
      sum_i        <= 4'h0;
      cnt          <= 4'h0;
      quot         <= '0;
      req_ready    <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_chan     <= 4'h0;
      rsp_data     <= '0;
      rsp_error    <= 1'b0;
      conv_a_start <= 1'b0;
      conv_b_start <= 1'b0;
      conv_a_mux   <= adc_readout_pkg::MUX_RESET;
      conv_b_mux   <= adc_readout_pkg::MUX_RESET;
    end
    else
    begin
      state        <= next_state;
      cur_idx      <= next_cur_idx;
      cur_chan     <= next_cur_chan;
      cur_depth    <= next_cur_depth;
      use_b        <= next_use_b;
      sample       <= next_sample;
      acc          <= next_acc;
      sum_i        <= next_sum_i;
      cnt          <= next_cnt;
      quot         <= next_quot;
      req_ready    <= next_req_ready;
      rsp_valid    <= next_rsp_valid;
      rsp_chan     <= next_rsp_chan;
      rsp_data     <= next_rsp_data;
      rsp_error    <= next_rsp_error;
      conv_a_start <= next_a_start;
      conv_b_start <= next_b_start;
      conv_a_mux   <= next_a_mux;
      conv_b_mux   <= next_b_mux;
    end
  end

  // history ring write: newest sample overwrites the oldest slot
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int c = 0; c < adc_readout_pkg::CHAN_COUNT; c++)
      begin
        wr_ptr[c] <= 4'h0;
        fill[c]   <= 4'h0;
      end
    end
    else if (do_store)
    begin
      hist[cur_idx][wr_ptr[cur_idx]] <= sample;
      wr_ptr[cur_idx] <= (wr_ptr[cur_idx] == 4'(MAX_DEPTH - 1)) ? 4'h0
                       : wr_ptr[cur_idx] + 4'h1;
      if (fill[cur_idx] < 4'(MAX_DEPTH))
        fill[cur_idx] <= fill[cur_idx] + 4'h1;
    end
  end

endmodule

// [adc_readout_pkg.sv]
// package for the eight-channel analog readout: widths, timing and channel map
// assumes a 250 MHz system clock
package adc_readout_pkg;
  localparam int          SAMPLE_BITS     = 12;
  localparam int          CHAN_COUNT      = 8;
  localparam int          CHAN_PER_CONV   = 4;
  localparam int          MAX_DEPTH       = 9;
  localparam int          CLK_PERIOD_NS   = 4;
  // one conversion must finish under 2 us; the converter handshake must stay below this
  localparam int          CONV_LIMIT_NS   = 2000;
  localparam int          CONV_LIMIT_CYC  = CONV_LIMIT_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  CHAN_FIRST      = 4'h1;
  localparam logic [3:0]  CHAN_LAST       = 4'h8;
  localparam logic [3:0]  DEPTH_RESET     = 4'h1;
  localparam logic [11:0] FULL_SCALE      = 12'hFFF;
  localparam logic [1:0]  MUX_RESET       = 2'h0;
endpackage

// [conv_model.sv]
// behavioural 12-bit converter with a four-input mux, far side of the readout
// assumes start is a one-cycle pulse and mux is held from start onward
`timescale 1ns/1ns
module conv_model
(
  // clock
  input  wire logic        sys_clk,
  // control from readout
  input  wire logic        start,
  input  wire logic [1:0]  mux,
  // analog levels and delay set by the bench
  input  wire logic [47:0] level,
  input  wire logic [7:0]  lag,
  // result to readout
  output logic             done,
  output logic [11:0]      data
);
  initial
  begin
    done = 1'b0;
    data = 12'h000;
  end
  // converts only on start; data settles two cycles before done, done pulses three cycles
  always
  begin
    @(posedge sys_clk);
    if (start === 1'b1)
    begin
      done <= 1'b0;
      data <= ~data;
      // at least one edge between the scrambled and the settled data
      repeat (int'(lag) + 1) @(posedge sys_clk);
      data <= level[mux*12 +: 12];
      repeat (2) @(posedge sys_clk);
      done <= 1'b1;
      // done falls well before the next start, so a stale done is never reused
      repeat (3) @(posedge sys_clk);
      done <= 1'b0;
    end
  end
endmodule

// [adc_readout_checker.sv]
// port assertions for the readout: routing, refusal, answer timing
// assumes one request in flight and synchronous active-high rst
`timescale 1ns/1ns
module adc_readout_checker
#(
  parameter int SAMPLE_BITS = 12,
  parameter int MAX_DEPTH   = 9
)
(
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst,
  // request side
  input wire logic                   req_valid,
  input wire logic [3:0]             req_chan,
  input wire logic                   avg_enable,
  input wire logic [3:0]             avg_depth,
  input wire logic                   req_ready,
  input wire logic                   rsp_valid,
  input wire logic [3:0]             rsp_chan,
  input wire logic [SAMPLE_BITS-1:0] rsp_data,
  input wire logic                   rsp_error,
  // converter controls
  input wire logic                   conv_a_start,
  input wire logic [1:0]             conv_a_mux,
  input wire logic                   conv_b_start,
  input wire logic [1:0]             conv_b_mux
);
  logic       take;
  logic       good;
  logic       fast;
  logic [1:0] want_mux;
  assign take = req_valid && req_ready;
  assign good = req_chan >= 4'h1 && req_chan <= 4'h8;
  assign fast = !avg_enable || avg_depth <= 4'h1;
  assign want_mux = req_chan[1:0] - 2'h1;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  route_a_a: assert property (take && good && req_chan <= 4'h4 |-> ##2
    (conv_a_start && !conv_b_start && conv_a_mux == $past(want_mux, 2)))
    else $error("wrong start on first converter");
  route_b_a: assert property (take && req_chan >= 4'h5 && good |-> ##2
    (conv_b_start && !conv_a_start && conv_b_mux == $past(want_mux, 2)))
    else $error("wrong start on second converter");
  bad_index_a: assert property (take && !good |=>
    rsp_valid && rsp_error && rsp_data == '0) else $error("bad index not refused");
  no_bg_start_a: assert property (conv_a_start || conv_b_start |-> $past(take, 2))
    else $error("start without request");
  busy_refuse_a: assert property (take |=> !req_ready)
    else $error("ready while busy");
  ready_back_a: assert property (rsp_valid |=> req_ready)
    else $error("ready not back after answer");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer strobe too long");
  hold_data_a: assert property (!rsp_valid && !$past(rst) |->
    $stable(rsp_data) && $stable(rsp_chan) && $stable(rsp_error))
    else $error("answer changed without strobe");
  conv_time_a: assert property (take && good && fast |-> ##[4:500] rsp_valid)
    else $error("answer later than 2 us");
endmodule
bind adc_readout adc_readout_checker #(.SAMPLE_BITS(SAMPLE_BITS), .MAX_DEPTH(MAX_DEPTH))
  adc_readout_checker_inst (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
  .req_chan(req_chan), .avg_enable(avg_enable), .avg_depth(avg_depth),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_chan(rsp_chan),
  .rsp_data(rsp_data), .rsp_error(rsp_error), .conv_a_start(conv_a_start),
  .conv_a_mux(conv_a_mux), .conv_b_start(conv_b_start), .conv_b_mux(conv_b_mux));

// [adc_readout_tb_top.sv]
// self-checking bench for the eight-channel readout with two converter models
// assumes one request in flight and a floor mean over the channel history
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module adc_readout_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic [3:0]  req_chan = 4'h1;
  logic        avg_enable = 1'b0;
  logic [3:0]  avg_depth = 4'h1;
  logic        req_ready, rsp_valid, rsp_error, a_start, b_start, a_done, b_done;
  logic [3:0]  rsp_chan;
  logic [11:0] rsp_data, a_data, b_data;
  logic [1:0]  a_mux, b_mux;
  logic [47:0] a_level = 48'h0;
  logic [47:0] b_level = 48'h0;
  logic [7:0]  lag = 8'h00;
  logic [16:0] e_rsp;
  logic [16:0] exp_q[$];
  int          hist[8][$];
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          starts = 0;
  int          goods = 0;
  int          seed = 32'h037C;
  always #2 sys_clk = ~sys_clk;
  adc_readout adc_readout_inst (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_chan(req_chan), .avg_enable(avg_enable), .avg_depth(avg_depth),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_chan(rsp_chan),
    .rsp_data(rsp_data), .rsp_error(rsp_error), .conv_a_start(a_start),
    .conv_a_mux(a_mux), .conv_a_done(a_done), .conv_a_data(a_data),
    .conv_b_start(b_start), .conv_b_mux(b_mux), .conv_b_done(b_done),
    .conv_b_data(b_data));
  conv_model conv_model_a_inst (.sys_clk(sys_clk), .start(a_start), .mux(a_mux),
    .level(a_level), .lag(lag), .done(a_done), .data(a_data));
  conv_model conv_model_b_inst (.sys_clk(sys_clk), .start(b_start), .mux(b_mux),
    .level(b_level), .lag(lag), .done(b_done), .data(b_data));
  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // called at a falling edge; returns once the answer has been checked
  task automatic request(input logic [3:0] ch, input logic en, input logic [3:0] dp,
                         input logic [11:0] v);
    int d;
    int n;
    int sum;
    int k;
    d = (!en || dp == 4'h0) ? 1 : (dp > 4'h9 ? 9 : int'(dp));
    k = int'(ch) - 1;
    if (ch >= 4'h1 && ch <= 4'h8)
    begin
      if (k < 4) a_level[k*12 +: 12] = v;
      else b_level[(k-4)*12 +: 12] = v;
      hist[k].push_front(int'(v));
      if (hist[k].size() > 9) void'(hist[k].pop_back());
      n = hist[k].size() < d ? hist[k].size() : d;
      sum = 0;
      for (int i = 0; i < n; i++) sum += hist[k][i];
      exp_q.push_back({1'b0, ch, 12'(sum / n)});
      goods++;
    end
    else
      exp_q.push_back({1'b1, ch, 12'h000});
    req_valid = 1'b1;
    req_chan = ch;
    avg_enable = en;
    avg_depth = dp;
    @(posedge sys_clk);
    while (req_ready !== 1'b1) @(posedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
    while (exp_q.size() != 0) @(negedge sys_clk);
    @(negedge sys_clk);
  endtask
  always @(posedge sys_clk)
    if (rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else
      begin
        e_rsp = exp_q.pop_front();
        `CHK({rsp_error, rsp_chan, rsp_data}, e_rsp)
      end
    end
  always @(posedge sys_clk)
  begin
    if (a_start === 1'b1 || b_start === 1'b1) starts++;
    cycles++;
    if (cycles == 90000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    // raw readings on every channel, odd channels at full scale and even channels at zero
    for (int c = 1; c <= 8; c++) request(4'(c), 1'b0, 4'h5, c[0] ? 12'hFFF : 12'h000);
    request(4'h0, 1'b1, 4'h3, 12'h555);
    request(4'h9, 1'b0, 4'h1, 12'h555);
    request(4'hF, 1'b1, 4'h9, 12'h555);
    // ring wraps past nine entries, then shorter and clamped windows
    lag = 8'h28;
    for (int i = 0; i < 10; i++) request(4'h6, 1'b1, 4'h9, 12'(100 * i + 7));
    request(4'h6, 1'b1, 4'h3, 12'h123);
    request(4'h6, 1'b1, 4'h0, 12'h456);
    request(4'h6, 1'b1, 4'hC, 12'h789);
    // reset mid-run empties the histories
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) hist[i].delete();
    repeat (2) @(negedge sys_clk);
    request(4'h6, 1'b1, 4'h9, 12'hABC);
    for (int i = 0; i < 24; i++)
    begin
      lag = 8'($random(seed) & 32'h1F);
      request(4'($random(seed)), 1'($random(seed)), 4'($random(seed)), 12'($random(seed)));
    end
    `CHK(starts, goods)
    final_report();
  end
endmodule
